// file: logic/spi_eeprom_core.sv
// Purpose: Opcode decode, array access and write protection of a serial EEPROM
// Assumes: SPI pins are asynchronous; sck is at least ten system clocks per period
// Notes:   Array contents and page buffer hold no reset, as nonvolatile storage
module spi_eeprom_core #(
  parameter bit BIG_ARRAY    = 1'b1,
  parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Serial link pins
  input  wire logic chip_sel_n_i,
  input  wire logic sck_i,
  input  wire logic sdi_i,
  input  wire logic hold_n_i,
  input  wire logic write_prot_n_i,
  // Serial output with its enable
  output logic      sdo_o,
  output logic      sdo_oe_n_o
);

  localparam int CW        = $clog2(WRITE_CYCLES + 1);
  localparam int ARR_BYTES = BIG_ARRAY ? spi_eeprom_pkg::BYTES_BIG : spi_eeprom_pkg::BYTES_SMALL;
  localparam logic [14:0] ADDR_MASK =
    BIG_ARRAY ? spi_eeprom_pkg::ADDR_MASK_BIG : spi_eeprom_pkg::ADDR_MASK_SMALL;
  localparam int Q_SHIFT =
    BIG_ARRAY ? spi_eeprom_pkg::QUARTER_SHIFT_BIG : spi_eeprom_pkg::QUARTER_SHIFT_SMALL;

  logic [4:0]                  pins_s;
  logic                        s_cs_n, s_sck, s_sdi, s_hold_n, s_wp_n;
  logic                        sck_q, cs_q, paused;
  spi_eeprom_pkg::link_state_e state, next_state, opc_next;
  logic [2:0]                  bit_cnt;
  logic [6:0]                  in_sr;
  logic [14:0]                 addr;
  logic                        wr_cmd, latch, busy, commit_stat, commit_run, stat_got;
  logic [CW-1:0]               busy_cnt;
  logic [5:0]                  commit_idx;
  logic                        guard_lo, guard_hi, pin_prot_en;
  logic [7:0]                  stat_pending, out_reg;
  logic [63:0]                 page_valid;
  logic [7:0]                  mem [0:ARR_BYTES-1];
  logic [7:0]                  page_data [0:63];

  pin_sync #(
    .WIDTH   (spi_eeprom_pkg::PIN_COUNT),
    .RST_VAL (spi_eeprom_pkg::PIN_IDLE)
  ) u_sync (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i   ({chip_sel_n_i, sck_i, sdi_i, hold_n_i, write_prot_n_i}),
    .synced_o (pins_s)
  );

  assign {s_cs_n, s_sck, s_sdi, s_hold_n, s_wp_n} = pins_s;

  // Edge detection; hold freezes both sck edges without losing position
  wire   active     = ~s_cs_n & ~paused;
  wire   sck_rise   = s_sck & ~sck_q & active;
  wire   sck_fall   = ~s_sck & sck_q & active;
  wire   cs_fall    = ~s_cs_n & cs_q;
  wire   cs_rise    = s_cs_n & ~cs_q;
  wire   byte_done  = sck_rise & (bit_cnt == spi_eeprom_pkg::BIT_LAST);
  wire [7:0] rx_byte = {in_sr, s_sdi};
  wire   opcode_done = byte_done & (state == spi_eeprom_pkg::ST_OPCODE);
  wire   opc_ok     = rx_byte[7:4] == spi_eeprom_pkg::OPC_HIGH_ZERO;
  wire [2:0] opc    = rx_byte[2:0];
  wire   op_set     = opcode_done & opc_ok & ~busy & (opc == spi_eeprom_pkg::OPC_SET_LATCH);
  wire   op_clr     = opcode_done & opc_ok & ~busy & (opc == spi_eeprom_pkg::OPC_CLR_LATCH);
  wire   op_srd     = opcode_done & opc_ok & (opc == spi_eeprom_pkg::OPC_STAT_RD);
  wire   hw_prot    = ~s_wp_n & pin_prot_en;
  wire   out_state  = (state == spi_eeprom_pkg::ST_RD_DATA) |
                      (state == spi_eeprom_pkg::ST_STAT_OUT);
  wire [14:0] hi_addr = {rx_byte[6:0], addr[7:0]} & ADDR_MASK;
  wire [14:0] lo_addr = {addr[14:8], rx_byte} & ADDR_MASK;
  wire [14:0] inc_addr = (addr + 15'h0001) & ADDR_MASK;
  wire [14:0] rd_addr = (state == spi_eeprom_pkg::ST_ADDR_LO) ? lo_addr : addr;
  wire [7:0]  rd_byte = mem[rd_addr];
  wire [1:0]  quarter = 2'(addr >> Q_SHIFT);
  wire [1:0]  guard_code = {guard_hi, guard_lo};
  wire [5:0]  page_next = addr[5:0] + 6'h01;
  wire        done_cnt = busy_cnt == CW'(0);

  wire page_guarded = (guard_code == spi_eeprom_pkg::GUARD_NONE)    ? 1'b0 :
                      (guard_code == spi_eeprom_pkg::GUARD_QUARTER) ?
                        (quarter == spi_eeprom_pkg::TOP_QUARTER) :
                      (guard_code == spi_eeprom_pkg::GUARD_HALF)    ? quarter[1] : 1'b1;

  // Programming starts only on a byte boundary and never while busy
  wire start_arr  = cs_rise & (state == spi_eeprom_pkg::ST_WR_DATA) &
                    (bit_cnt == 3'h0) & (|page_valid) & latch & ~busy &
                    ~page_guarded;
  wire start_stat = cs_rise & (state == spi_eeprom_pkg::ST_STAT_IN) &
                    (bit_cnt == 3'h0) & stat_got & latch & ~busy &
                    ~hw_prot;
  wire start_write = start_arr | start_stat;

  wire [7:0] status_view = busy ? spi_eeprom_pkg::STATUS_BUSY_VIEW :
    (spi_eeprom_pkg::STATUS_CLEAR |
     (8'(pin_prot_en) << spi_eeprom_pkg::ST_PIN_PROT) |
     (8'(guard_hi)    << spi_eeprom_pkg::ST_GUARD_HI) |
     (8'(guard_lo)    << spi_eeprom_pkg::ST_GUARD_LO) |
     (8'(latch)       << spi_eeprom_pkg::ST_LATCH));

  always_comb begin
    opc_next = spi_eeprom_pkg::ST_IGNORE;
    if (opc_ok) begin
      case (opc)
        spi_eeprom_pkg::OPC_STAT_RD: opc_next = spi_eeprom_pkg::ST_STAT_OUT;
        spi_eeprom_pkg::OPC_STAT_WR: opc_next = (latch & ~busy) ?
                                       spi_eeprom_pkg::ST_STAT_IN : spi_eeprom_pkg::ST_IGNORE;
        spi_eeprom_pkg::OPC_ARR_RD:  opc_next = busy ?
                                       spi_eeprom_pkg::ST_IGNORE : spi_eeprom_pkg::ST_ADDR_HI;
        spi_eeprom_pkg::OPC_ARR_WR:  opc_next = (latch & ~busy) ?
                                       spi_eeprom_pkg::ST_ADDR_HI : spi_eeprom_pkg::ST_IGNORE;
        default:                     opc_next = spi_eeprom_pkg::ST_IGNORE;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    if (s_cs_n) begin
      next_state = spi_eeprom_pkg::ST_IDLE;
    end else if (cs_fall) begin
      next_state = spi_eeprom_pkg::ST_OPCODE;
    end else if (byte_done) begin
      case (state)
        spi_eeprom_pkg::ST_OPCODE:  next_state = opc_next;
        spi_eeprom_pkg::ST_ADDR_HI: next_state = spi_eeprom_pkg::ST_ADDR_LO;
        spi_eeprom_pkg::ST_ADDR_LO: next_state = wr_cmd ? spi_eeprom_pkg::ST_WR_DATA :
                                                         spi_eeprom_pkg::ST_RD_DATA;
        default:                    next_state = state;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sck_q  <= 1'b0;
      cs_q   <= 1'b1;
      paused <= 1'b0;
    end else begin
      sck_q <= s_sck;
      cs_q  <= s_cs_n;
      // Hold only changes while sck is low so a pause never splits an edge
      if (s_cs_n) begin
        paused <= 1'b0;
      end else if (~s_sck) begin
        paused <= ~s_hold_n;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state   <= spi_eeprom_pkg::ST_IDLE;
      bit_cnt <= 3'h0;
      in_sr   <= 7'h00;
    end else begin
      state <= next_state;
      if (cs_fall) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        in_sr   <= rx_byte[6:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr   <= 15'h0000;
      wr_cmd <= 1'b0;
    end else if (byte_done) begin
      case (state)
        spi_eeprom_pkg::ST_OPCODE:  wr_cmd <= opc == spi_eeprom_pkg::OPC_ARR_WR;
        spi_eeprom_pkg::ST_ADDR_HI: addr <= hi_addr;
        spi_eeprom_pkg::ST_ADDR_LO: addr <= wr_cmd ? lo_addr : ((lo_addr + 15'h0001) & ADDR_MASK);
        spi_eeprom_pkg::ST_RD_DATA: addr <= inc_addr;
        spi_eeprom_pkg::ST_WR_DATA: addr <= {addr[14:6], page_next};
        default:                    addr <= addr;
      endcase
    end
  end

  // Status write data waits for chip select to rise before it may count
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_pending <= spi_eeprom_pkg::STATUS_CLEAR;
      stat_got     <= 1'b0;
    end else if (cs_fall) begin
      stat_got <= 1'b0;
    end else if (byte_done & (state == spi_eeprom_pkg::ST_STAT_IN)) begin
      stat_pending <= rx_byte;
      stat_got     <= 1'b1;
    end
  end

  // Timed write engine; latch clear on completion
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch       <= 1'b0;
      busy        <= 1'b0;
      busy_cnt    <= CW'(0);
      commit_stat <= 1'b0;
      guard_lo    <= 1'b0;
      guard_hi    <= 1'b0;
      pin_prot_en <= 1'b0;
    end else begin
      if (start_write) begin
        busy        <= 1'b1;
        busy_cnt    <= CW'(WRITE_CYCLES - 1);
        commit_stat <= start_stat;
      end else if (busy) begin
        if (done_cnt) begin
          busy  <= 1'b0;
          latch <= 1'b0;
          if (commit_stat) begin
            guard_lo    <= stat_pending[spi_eeprom_pkg::ST_GUARD_LO];
            guard_hi    <= stat_pending[spi_eeprom_pkg::ST_GUARD_HI];
            pin_prot_en <= stat_pending[spi_eeprom_pkg::ST_PIN_PROT];
          end
        end else begin
          busy_cnt <= busy_cnt - CW'(1);
        end
      end
      if (op_clr) begin
        latch <= 1'b0;
      end
      if (op_set) begin
        latch <= 1'b1;
      end
    end
  end

  // Page buffer is copied into the array one entry per clock at cycle start
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      commit_run <= 1'b0;
      commit_idx <= 6'h00;
      page_valid <= 64'h0000_0000_0000_0000;
    end else begin
      if (start_arr) begin
        commit_run <= 1'b1;
        commit_idx <= 6'h00;
      end else if (commit_run) begin
        commit_idx <= commit_idx + 6'h01;
        if (commit_idx == spi_eeprom_pkg::PAGE_LAST) begin
          commit_run <= 1'b0;
          page_valid <= 64'h0000_0000_0000_0000;
        end
      end
      if (cs_fall & ~busy) begin
        page_valid <= 64'h0000_0000_0000_0000;
      end else if (byte_done & (state == spi_eeprom_pkg::ST_WR_DATA)) begin
        page_valid[addr[5:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (byte_done & (state == spi_eeprom_pkg::ST_WR_DATA)) begin
      page_data[addr[5:0]] <= rx_byte;
    end
    if (commit_run & page_valid[commit_idx]) begin
      mem[{addr[14:6], commit_idx}] <= page_data[commit_idx];
    end
  end

  // Output launches on sck falling edges only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_reg    <= 8'h00;
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end else begin
      sdo_oe_n_o <= ~(out_state & active);
      if (op_srd | (byte_done & (state == spi_eeprom_pkg::ST_STAT_OUT))) begin
        out_reg <= status_view;
      end else if (byte_done & ((state == spi_eeprom_pkg::ST_RD_DATA) |
                                ((state == spi_eeprom_pkg::ST_ADDR_LO) & ~wr_cmd))) begin
        out_reg <= rd_byte;
      end else if (sck_fall & out_state) begin
        sdo_o   <= out_reg[7];
        out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence opcode_seen_s(logic [2:0] code);
    opcode_done && opc_ok && (opc == code) && !busy;
  endsequence

  latch_set_a: assert property (opcode_seen_s(spi_eeprom_pkg::OPC_SET_LATCH) |=> latch)
    else $error("set latch opcode did not set the latch");
  latch_clear_a: assert property (opcode_seen_s(spi_eeprom_pkg::OPC_CLR_LATCH) |=> !latch)
    else $error("clear latch opcode left the latch set");
  busy_view_a: assert property (op_srd && busy |=>
                                out_reg == spi_eeprom_pkg::STATUS_BUSY_VIEW)
    else $error("status not all ones while busy");
  end_latch_a: assert property ($fell(busy) |-> !latch)
    else $error("latch still set after write cycle");
  write_needs_latch_a: assert property ($rose(busy) |-> $past(latch))
    else $error("write cycle started without latch");
  stat_prot_a: assert property ($rose(busy) && commit_stat |-> !$past(hw_prot))
    else $error("status write under hardware protection");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("write cycle ended too early");
  read_wrap_a: assert property (byte_done && state == spi_eeprom_pkg::ST_RD_DATA &&
                                addr == ADDR_MASK |=> addr == 15'h0000)
    else $error("read address did not wrap to zero");
  page_fixed_a: assert property (byte_done && state == spi_eeprom_pkg::ST_WR_DATA |=>
                                 addr[14:6] == $past(addr[14:6]))
    else $error("page write changed upper address bits");
  ignore_quiet_a: assert property (state == spi_eeprom_pkg::ST_IGNORE |=> sdo_oe_n_o)
    else $error("output driven after unknown opcode");

endmodule : spi_eeprom_core

// file: inc/spi_eeprom_pkg.sv
// Purpose: Shared constants for the serial EEPROM command and protection logic
// Assumes: 125 MHz system clock; SPI mode 0 or 3 seen from the device side
// Notes:   Overview of operation follows
// Overview of operation
// - Transactions start at chip select falling; bytes arrive MSB first, opcode first.
// - Decode 0000x110 set latch, 0000x100 clear latch, 0000x101 status read.
// - Decode 0000x001 status write, 0000x011 array read, 0000x010 array write.
// - Write latch is clear after reset; master sets it before each programming.
// - Clear latch command disables programming regardless of write protect pin.
// - Status bit 0 is one while internal write runs, zero when ready.
// - Status bit 1 shows latch; bits 3..2 block guards; bit 7 pin protect.
// - Status bits 6..4 read zero when idle; all bits read one while busy.
// - Small array guards: 01 top quarter, 10 top half, 11 everything.
// - Large array guards: 01 6000-7FFF, 10 4000-7FFF, 11 0000-7FFF.
// - Guard and pin protect bits are nonvolatile, need latch and timed cycle; here sys_rst_i clears them to zero.
// - Pin low with pin protect enabled refuses every status write.
// - Guarded regions never written; others and status need latch set.
// - Pin protect bit cannot return to zero while pin held low.
// - Array read ignores input after address and shifts bytes out MSB first.
// - Read address increments per byte and wraps to zero past the top.
// - Array write takes opcode, address, data; programming starts at chip select rise.
// - While busy only status read is honoured.
// - Page write increments six low address bits; upper bits stay fixed.
// - Write latch clears itself when the internal write cycle ends.
// - Write without latch is ignored until the next chip select falling edge.
// - Address is 16 bits; unused upper bits are ignored per array size.
// - Unknown opcode: ignore input, output stays released until next select.
// - Hold low with clock low pauses; release with clock low resumes.
package spi_eeprom_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_OPCODE   = 4'h1,
    ST_ADDR_HI  = 4'h2,
    ST_ADDR_LO  = 4'h3,
    ST_RD_DATA  = 4'h4,
    ST_WR_DATA  = 4'h5,
    ST_STAT_OUT = 4'h6,
    ST_STAT_IN  = 4'h7,
    ST_IGNORE   = 4'h8
  } link_state_e;

  // Opcode upper nibble must be zero, bit 3 is a don't care
  localparam logic [3:0] OPC_HIGH_ZERO = 4'h0;
  localparam logic [2:0] OPC_SET_LATCH = 3'h6;
  localparam logic [2:0] OPC_CLR_LATCH = 3'h4;
  localparam logic [2:0] OPC_STAT_RD   = 3'h5;
  localparam logic [2:0] OPC_STAT_WR   = 3'h1;
  localparam logic [2:0] OPC_ARR_RD    = 3'h3;
  localparam logic [2:0] OPC_ARR_WR    = 3'h2;

  // protection_status field positions
  localparam int ST_BUSY     = 0;
  localparam int ST_LATCH    = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_PIN_PROT = 7;
  localparam logic [7:0] STATUS_BUSY_VIEW = 8'hFF;
  localparam logic [7:0] STATUS_CLEAR     = 8'h00;

  localparam logic [1:0] GUARD_NONE    = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF    = 2'h2;
  localparam logic [1:0] TOP_QUARTER   = 2'h3;

  localparam int ADDR_W      = 15;
  localparam int PAGE_BITS   = 6;
  localparam int BYTES_BIG   = 32768;
  localparam int BYTES_SMALL = 16384;
  localparam logic [14:0] ADDR_MASK_BIG   = 15'h7FFF;
  localparam logic [14:0] ADDR_MASK_SMALL = 15'h3FFF;
  localparam int QUARTER_SHIFT_BIG   = 13;
  localparam int QUARTER_SHIFT_SMALL = 12;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [5:0] PAGE_LAST  = 6'h3F;

  // Pin bundle order {cs_n, sck, sdi, hold_n, wp_n}; idle levels at reset
  localparam int PIN_COUNT = 5;
  localparam logic [4:0] PIN_IDLE = 5'h13;

  localparam int WRITE_TIME_MS = 5;
  localparam int CLK_KHZ       = 125000;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * CLK_KHZ;

endpackage : spi_eeprom_pkg

// file: logic/pin_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins
// Assumes: Every bit is an independent level
// Notes:   Reset value per bit comes from a parameter constant
module pin_sync #(
  parameter int                 WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Pins and synchronised copies
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] synced_o
);

  logic [WIDTH-1:0] meta;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        meta[i]     <= RST_VAL[i];
        synced_o[i] <= RST_VAL[i];
      end else begin
        meta[i]     <= pins_i[i];
        synced_o[i] <= meta[i];
      end
    end
  end

endmodule : pin_sync

// file: tb/spi_master_model.sv
// Purpose: SPI master model that drives the EEPROM core pins in mode 0
// Assumes: sck half period of five system clocks
// Notes:   A released sdo reads inverted, so a stale bit can never pass a compare
module spi_master_model (
  // Clock
  input  wire logic clk_i,
  // From the device
  input  wire logic sdo_i,
  input  wire logic sdo_oe_n_i,
  // To the device
  output logic      chip_sel_n_o,
  output logic      sck_o,
  output logic      sdi_o,
  output logic      hold_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_sel_n_o = 1'b1;
    sck_o        = 1'b0;
    sdi_o        = 1'b0;
    hold_n_o     = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // Select rises in the low phase after the last bit; sdi then stops carrying data
  task automatic sel(input logic lvl);
    tick(lvl ? 2 : 4);
    chip_sel_n_o = lvl;
    sdi_o        = ~sdi_o;
    tick(lvl ? 10 : 5);
  endtask : sel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = tx[i];
      tick(5);
      sck_o = 1'b1;
      rx[i] = sdo_oe_n_i ? ~sdo_i : sdo_i;
      tick(5);
      sck_o = 1'b0;
    end
  endtask : xfer
  // Hold moves only while sck is low; the pulses in between must not count
  task automatic pause(input int n, output logic [7:0] oe_seen);
    hold_n_o = 1'b0;
    tick(5);
    repeat (n) begin
      sck_o = 1'b1;
      tick(5);
      sck_o = 1'b0;
      tick(5);
    end
    oe_seen  = {7'h00, sdo_oe_n_i};
    hold_n_o = 1'b1;
    tick(5);
  endtask : pause
endmodule : spi_master_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the serial EEPROM command and protection logic
// Assumes: 32K array; write cycle shortened to keep the run brief
// Notes:   Expected bytes sit in a sparse table; only written places are read back
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR_CYCLES = 1000;
  logic        clk;
  logic        sys_rst;
  logic        write_prot_n;
  wire logic   chip_sel_n, sck, sdi, hold_n, sdo, sdo_oe_n;
  int          errors, checks;
  int          cycles = 0;
  logic [7:0]  s;
  logic [7:0]  mem [logic [14:0]];
  logic [15:0] guard_lo [1:3] = '{16'h6000, 16'h4000, 16'h0000};
  logic [7:0]  bad_ops [3] = '{8'h07, 8'h16, 8'h80};
  spi_eeprom_core #(.BIG_ARRAY(1'b1), .WRITE_CYCLES(WR_CYCLES)) dut_u (
    .clk_i(clk), .sys_rst_i(sys_rst), .chip_sel_n_i(chip_sel_n), .sck_i(sck), .sdi_i(sdi),
    .hold_n_i(hold_n), .write_prot_n_i(write_prot_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n));
  spi_master_model master_u (
    .clk_i(clk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .chip_sel_n_o(chip_sel_n), .sck_o(sck),
    .sdi_o(sdi), .hold_n_o(hold_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // The whole sequence needs about half of this budget
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      $display("mismatch at %0t: run took too long", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input bit two);
    master_u.sel(1'b0);
    master_u.xfer(op, s);
    if (two) master_u.xfer(dat, s);
    master_u.sel(1'b1);
  endtask : frame
  task automatic stat_is(input logic [7:0] exp, input string what);
    frame(8'h05, 8'hC3, 1'b1);
    check(s, exp, what);
  endtask : stat_is
  // For writes a nonzero arg records the bytes as expected contents;
  // for reads it pauses the link with hold before every data byte
  task automatic xact(input logic [7:0] op, input logic [15:0] a, input int n,
                      input logic [7:0] d0, input int arg);
    logic [7:0] r;
    master_u.sel(1'b0);
    master_u.xfer(op, r);
    master_u.xfer(a[15:8], r);
    master_u.xfer(a[7:0], r);
    if (n == 0) check({7'h00, sdo_oe_n}, 8'h01, "output released");
    for (int k = 0; k < n; k++) begin
      if (op[0] && arg != 0) begin
        master_u.pause(3, r);
        check(r, 8'h01, "output released in hold");
      end
      master_u.xfer(d0 + k[7:0], r);
      if (op[0]) check(r, mem[15'(a[14:0] + k[14:0])], "array byte");
      else if (arg != 0) mem[{a[14:6], a[5:0] + k[5:0]}] = d0 + k[7:0];
    end
    master_u.sel(1'b1);
  endtask : xact
  task automatic wait_ready();
    s = 8'hFF;
    for (int t = 0; t < 30 && s[0] !== 1'b0; t++) frame(8'h05, 8'hC3, 1'b1);
    check({7'h00, s[0]}, 8'h00, "write cycle end");
  endtask : wait_ready
  initial begin
    sys_rst = 1'b1;
    write_prot_n = 1'b1;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    stat_is(8'h00, "after reset");
    frame(8'h0E, 8'h00, 1'b0);
    frame(8'h0D, 8'hC3, 1'b1);
    check(s, 8'h02, "latch set");
    write_prot_n = 1'b0;
    frame(8'h04, 8'h00, 1'b0);
    stat_is(8'h00, "latch cleared");
    write_prot_n = 1'b1;
    foreach (bad_ops[i]) xact(bad_ops[i], 16'h0606, 0, 8'h00, 0);
    stat_is(8'h00, "bad opcodes");
    $display("test opcodes done");
    frame(8'h06, 8'h00, 1'b0);
    xact(8'h02, 16'h0030, 66, 8'h40, 1);
    stat_is(8'hFF, "busy view");
    xact(8'h03, 16'h0000, 0, 8'h00, 0);
    frame(8'h06, 8'h00, 1'b0);
    wait_ready();
    stat_is(8'h00, "latch after cycle");
    xact(8'h03, 16'h8000, 64, 8'hA5, 0);
    xact(8'h0A, 16'h0005, 1, 8'hEE, 0);
    stat_is(8'h00, "write without latch");
    frame(8'h06, 8'h00, 1'b0);
    xact(8'h02, 16'h7FFE, 2, 8'h11, 1);
    wait_ready();
    xact(8'h0B, 16'h7FFE, 3, 8'h5A, 1);
    $display("test array done");
    for (int c = 1; c < 4; c++) begin
      frame(8'h06, 8'h00, 1'b0);
      frame(8'h01, {4'h0, c[1:0], 2'h0}, 1'b1);
      wait_ready();
      frame(8'h06, 8'h00, 1'b0);
      xact(8'h02, guard_lo[c], 1, 8'h77, 0);
      stat_is({4'h0, c[1:0], 2'h2}, "guarded write");
      xact(8'h02, guard_lo[c] - 16'h0001, 1, 8'h78, 0);
      stat_is((c == 3) ? 8'h0E : 8'hFF, "below guard");
      wait_ready();
    end
    frame(8'h06, 8'h00, 1'b0);
    frame(8'h01, 8'h80, 1'b1);
    wait_ready();
    write_prot_n = 1'b0;
    frame(8'h06, 8'h00, 1'b0);
    frame(8'h01, 8'h00, 1'b1);
    stat_is(8'h82, "status write under pin");
    write_prot_n = 1'b1;
    frame(8'h09, 8'h00, 1'b1);
    wait_ready();
    stat_is(8'h00, "status write released");
    $display("test protect done");
    wrap_up();
  end
endmodule : tb_top
